// [logic/cstg_params.svh]
`ifndef CSTG_PARAMS_SVH
`define CSTG_PARAMS_SVH
// register byte offsets
`define CSTG_OFF_CTRL    8'h00
`define CSTG_OFF_LIM0    8'h04
`define CSTG_OFF_LIM_END 8'h20
`define CSTG_OFF_STATUS  8'h24
// limit table indices (offset = LIM0 + 4 * index)
`define CSTG_HRZT  3'h0
`define CSTG_HRZSR 3'h1
`define CSTG_HRZBR 3'h2
`define CSTG_HRZBF 3'h3
`define CSTG_VRTT  3'h4
`define CSTG_VRTSR 3'h5
`define CSTG_VRTBR 3'h6
`define CSTG_VRTBF 3'h7
// control field positions
`define CSTG_CTRL_EXT    0
`define CSTG_CTRL_EDGE   1
`define CSTG_CTRL_DLY    3:2
`define CSTG_CTRL_HPOL   5:4
`define CSTG_CTRL_VPOL   7:6
`define CSTG_CTRL_WIDTH  8
// reset values
`define CSTG_CTRL_RST   8'h00
`define CSTG_HRZT_RST   12'h0ff
`define CSTG_HRZSR_RST  12'h00f
`define CSTG_HRZBR_RST  12'h02f
`define CSTG_HRZBF_RST  12'h0ef
`define CSTG_VRTT_RST   12'h020
`define CSTG_VRTSR_RST  12'h002
`define CSTG_VRTBR_RST  12'h004
`define CSTG_VRTBF_RST  12'h01e
`endif

// [logic/cstg_pkg.sv]
`default_nettype none
package cstg_pkg;
  // polarity / force selection for one external sync pin
  typedef enum logic [1:0] {
    CSTG_POL_NORMAL = 2'h0,
    CSTG_POL_INVERT = 2'h1,
    CSTG_POL_LOW    = 2'h2,
    CSTG_POL_HIGH   = 2'h3
  } cstg_pol_type;

  // control register layout, msb first
  typedef struct packed {
    cstg_pol_type vpol;
    cstg_pol_type hpol;
    logic [1:0]   blank_dly;
    logic         blank_edge;
    logic         ext_sync;
  } cstg_ctrl_type;

  // live timing state for status readback
  typedef struct packed {
    logic [11:0] hcount;
    logic [11:0] vcount;
    logic        hsync_int_n;
    logic        vsync_int_n;
    logic        hblank;
    logic        vblank;
  } cstg_state_type;
endpackage
`default_nettype wire

// [logic/cstg_timing.sv]
// Operation
// R01 - separate active-low hsync, vsync, blank outputs
// R02 - polarity select and force per sync pin
// R03 - polarity applied only after internal signals
// R04 - internal or external sync source selectable
// R05 - horizontal counts in timing clock periods
// R06 - software programs horizontal limits minus one
// R07 - software keeps period limit multiple of 8/16
// R08 - software orders horizontal limits strictly ascending
// R09 - horizontal counter runs zero to limit, wraps
// R10 - hsync low for sync-end limit clocks
// R11 - two limits place horizontal blank edges
// R12 - vertical counter advances once per line
// R13 - software programs vertical limits as full count
// R14 - software orders vertical limits strictly ascending
// R15 - vertical counter runs zero to limit-1
// R16 - vsync low for sync-end lines
// R17 - two limits place vertical blank edges
// R18 - config bit selects timing clock output edge
// R19 - blank delayed zero to three shift clocks; code delays zero to three timing clock periods (output ticks)
// R20 - blank active when either interval active
`timescale 1ns/1ps
`default_nettype none
`include "cstg_params.svh"
module cstg_timing
  import cstg_pkg::*;
(
  input  wire logic        sys_clk_i,         // system clock, 25 MHz
  input  wire logic        rst_i,             // synchronous reset, active high
  input  wire logic        char_timing_clock_i, // character timing clock, sampled
  input  wire logic        ext_hsync_n_i,     // external horizontal sync, active low
  input  wire logic        ext_vsync_n_i,     // external vertical sync, active low
  input  wire logic        wb_cyc_i,          // wishbone cycle
  input  wire logic        wb_stb_i,          // wishbone strobe
  input  wire logic        wb_we_i,           // wishbone write enable
  input  wire logic [7:0]  wb_adr_i,          // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,          // wishbone byte selects
  input  wire logic [31:0] wb_dat_i,          // wishbone write data
  output logic      [31:0] wb_dat_o,          // wishbone read data
  output logic             wb_ack_o,          // wishbone acknowledge
  output logic             hsync_o,           // horizontal sync pin
  output logic             vsync_o,           // vertical sync pin
  output logic             blank_n_o          // composite blank, active low
);

  // ************************************************************
  // register bus decode
  // ************************************************************
  cstg_ctrl_type  ctrl;                 // control register
  logic [11:0]    lim [8];              // timing limit table
  cstg_state_type st;                   // live state
  wire            bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire            bus_wr    = bus_req & wb_we_i;
  wire            hit_ctrl  = (wb_adr_i == `CSTG_OFF_CTRL);
  wire            hit_stat  = (wb_adr_i == `CSTG_OFF_STATUS);
  wire            hit_lim   = (wb_adr_i >= `CSTG_OFF_LIM0) &&
                              (wb_adr_i <= `CSTG_OFF_LIM_END) &&
                              (wb_adr_i[1:0] == 2'h0);
  wire [7:0]      lim_off   = wb_adr_i - `CSTG_OFF_LIM0;
  wire [2:0]      lim_idx   = lim_off[4:2];
  wire [31:0]     rd_lim    = {20'h0, lim[lim_idx]};
  wire [31:0]     rd_stat   = {4'h0, st};
  wire [31:0]     rd_ctrl   = {24'h0, ctrl};
  // unmapped addresses read as zero and ignore writes
  wire [31:0]     next_rdat = hit_ctrl ? rd_ctrl :
                              hit_lim  ? rd_lim  :
                              hit_stat ? rd_stat : 32'h0;

  // single-cycle ack, dropped the cycle after it was given
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? next_rdat : 32'h0;
    end
  end

  // control register, low byte lane only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl <= cstg_ctrl_type'(`CSTG_CTRL_RST);
    end else if (bus_wr && hit_ctrl && wb_sel_i[0]) begin
      ctrl <= cstg_ctrl_type'(wb_dat_i[7:0]);
    end
  end

  // limit table: each entry takes lanes 0 and 1 on its own
  localparam logic [11:0] LIM_RST [8] = '{`CSTG_HRZT_RST, `CSTG_HRZSR_RST,
    `CSTG_HRZBR_RST, `CSTG_HRZBF_RST, `CSTG_VRTT_RST, `CSTG_VRTSR_RST,
    `CSTG_VRTBR_RST, `CSTG_VRTBF_RST};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_lim
      wire wr_me = bus_wr && hit_lim && (lim_idx == 3'(gi));
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          lim[gi] <= LIM_RST[gi];
        end else if (wr_me) begin
          if (wb_sel_i[0]) lim[gi][7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) lim[gi][11:8] <= wb_dat_i[11:8];
        end
      end
    end
  endgenerate

  // ************************************************************
  // timing clock edge detection
  // ************************************************************
  logic        ctc_q;                   // last sample of timing clock
  logic        ehs_q;                   // last sample of external hsync
  logic        evs_q;                   // last sample of external vsync
  wire         ctc_rise = char_timing_clock_i & ~ctc_q;
  wire         ctc_fall = ~char_timing_clock_i & ctc_q;
  // counters step on the rising edge; pins may follow the falling one
  wire         tick     = ctc_rise;                                  // R05
  wire         out_tick = ctrl.blank_edge ? ctc_fall : ctc_rise;     // R18
  wire         ehs_fall = ~ext_hsync_n_i & ehs_q;
  wire         evs_fall = ~ext_vsync_n_i & evs_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctc_q <= 1'b0;
      ehs_q <= 1'b1;
      evs_q <= 1'b1;
    end else begin
      ctc_q <= char_timing_clock_i;
      ehs_q <= ext_hsync_n_i;
      evs_q <= ext_vsync_n_i;
    end
  end

  // ************************************************************
  // horizontal and vertical counters
  // ************************************************************
  logic [11:0] hcount;                  // horizontal position, timing clocks
  logic [11:0] vcount;                  // vertical position, lines
  // external mode: a falling external sync seen on a tick restarts the counter
  wire         h_resync = ctrl.ext_sync & tick & ehs_fall;          // R04
  wire         v_resync = ctrl.ext_sync & tick & evs_fall;          // R04
  wire         h_wrap   = tick & (hcount >= lim[`CSTG_HRZT]);      // R09
  wire         line_end = h_wrap | h_resync;                        // R12
  wire [11:0]  vlast    = lim[`CSTG_VRTT] - 12'h1;
  wire         v_wrap   = line_end & (vcount >= vlast);             // R15
  wire [11:0]  next_h   = (h_wrap | h_resync) ? 12'h0 : hcount + 12'h1;
  wire [11:0]  next_v   = (v_wrap | v_resync) ? 12'h0 : vcount + 12'h1;

  // horizontal counter, zero to hrzt inclusive
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hcount <= 12'h0;
    end else if (tick) begin
      hcount <= next_h;                                              // R09
    end
  end

  // vertical counter, one step per line
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      vcount <= 12'h0;
    end else if (line_end || v_resync) begin
      vcount <= next_v;                                              // R12
    end
  end

  // ************************************************************
  // internal active-low sync and active-high blank intervals
  // ************************************************************
  // horizontal limits are count-1, so compares are inclusive
  wire hsync_int_n = ~(hcount <= lim[`CSTG_HRZSR]);                  // R10
  wire hblank      = ~((hcount > lim[`CSTG_HRZBR]) &&
                       (hcount <= lim[`CSTG_HRZBF]));                // R11
  // vertical limits are full counts, so compares are exclusive
  wire vsync_int_n = ~(vcount < lim[`CSTG_VRTSR]);                   // R16
  wire vblank      = ~((vcount >= lim[`CSTG_VRTBR]) &&
                       (vcount < lim[`CSTG_VRTBF]));                 // R17
  wire blank_any   = hblank | vblank;                                // R20
  assign st = '{hcount, vcount, hsync_int_n, vsync_int_n, hblank, vblank};

  // ************************************************************
  // blank delay line
  // ************************************************************
  logic [2:0] blank_dl;                 // delayed copies, one per out tick
  wire        blank_sel = (ctrl.blank_dly == 2'h0) ? blank_any :
                          blank_dl[ctrl.blank_dly - 2'h1];           // R19

  // shift on each output tick, so delay is in timing periods
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      blank_dl <= 3'h7;
    end else if (out_tick) begin
      blank_dl <= {blank_dl[1:0], blank_any};
    end
  end

  // ************************************************************
  // pin polarity and forcing
  // ************************************************************
  // done only here, so the generator itself never sees polarity
  function automatic logic pin_drive(input cstg_pol_type p, input logic s_n);
    case (p)
      CSTG_POL_NORMAL: pin_drive = s_n;
      CSTG_POL_INVERT: pin_drive = ~s_n;
      CSTG_POL_LOW:    pin_drive = 1'b0;
      CSTG_POL_HIGH:   pin_drive = 1'b1;
      default:         pin_drive = s_n;
    endcase
  endfunction

  wire next_hs = pin_drive(ctrl.hpol, hsync_int_n);                  // R02
  wire next_vs = pin_drive(ctrl.vpol, vsync_int_n);                  // R02

  // pins are registered and update only on the chosen edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hsync_o   <= 1'b1;
      vsync_o   <= 1'b1;
      blank_n_o <= 1'b0;
    end else if (out_tick) begin
      hsync_o   <= next_hs;                                          // R01 R03
      vsync_o   <= next_vs;                                          // R01 R03
      blank_n_o <= ~blank_sel;                                       // R01
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  hcount_wrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R09
    h_wrap |=> hcount == 12'h0)
    else $error("hcount did not wrap at period limit");

  hcount_step_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R05
    (tick && !h_wrap && !h_resync) |=> hcount == $past(hcount) + 12'h1)
    else $error("hcount did not step on timing clock");

  vcount_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R12
    (!line_end && !v_resync) |=> $stable(vcount))
    else $error("vcount moved inside a line");

  vcount_wrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R15
    (line_end && vcount == vlast) |=> vcount == 12'h0)
    else $error("vcount did not wrap at limit minus one");

  ext_resync_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R04
    h_resync |=> hcount == 12'h0 ##1 hcount == 12'h0)
    else $error("external hsync did not restart line");

  hsync_normal_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R03
    (out_tick && ctrl.hpol == CSTG_POL_NORMAL)
      |=> hsync_o == $past(hcount <= lim[`CSTG_HRZSR]) ^ 1'b1)
    else $error("hsync pin does not follow internal sync");

  vsync_force_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R02
    (out_tick && ctrl.vpol == CSTG_POL_HIGH) |=> vsync_o)
    else $error("vsync pin not forced high");

  blank_comb_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R20
    (out_tick && ctrl.blank_dly == 2'h0) |=> blank_n_o == !$past(hblank | vblank))
    else $error("blank pin is not or of intervals");

  edge_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R18
    (!out_tick && $stable(ctrl)) |=> $stable(hsync_o) && $stable(blank_n_o))
    else $error("pins changed off the selected edge");

  ack_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // a request that is taken is answered on the very next edge
  ack_timing_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged in one cycle");

  vcount_step_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R12
    (line_end && !v_resync && vcount < vlast) |=> vcount == $past(vcount) + 12'h1)
    else $error("vcount did not step at line end");

  vsync_normal_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R16
    (out_tick && ctrl.vpol == CSTG_POL_NORMAL)
      |=> vsync_o == !$past(vcount < lim[`CSTG_VRTSR]))
    else $error("vsync pin does not follow line count");

  hsync_invert_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R02
    (out_tick && ctrl.hpol == CSTG_POL_INVERT)
      |=> hsync_o == $past(hcount <= lim[`CSTG_HRZSR]))
    else $error("hsync pin not inverted");

  hsync_force_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R02
    (out_tick && ctrl.hpol == CSTG_POL_LOW) |=> !hsync_o)
    else $error("hsync pin not forced low");

  hblank_lead_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R11
    (out_tick && ctrl.blank_dly == 2'h0 && hcount <= lim[`CSTG_HRZBR]) |=> !blank_n_o)
    else $error("blank released before horizontal display start");

  vblank_lead_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R17
    (out_tick && ctrl.blank_dly == 2'h0 && vcount < lim[`CSTG_VRTBR]) |=> !blank_n_o)
    else $error("blank released before vertical display start");

  blank_delay_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R19
    (out_tick && ctrl.blank_dly == 2'h3) |=> blank_n_o == !$past(blank_dl[2]))
    else $error("blank not delayed by three ticks");

  edge_level_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R18
    out_tick |-> char_timing_clock_i != ctrl.blank_edge)
    else $error("pins moved on the wrong timing clock edge");

endmodule // cstg_timing
`default_nettype wire

// [test/cstg_monitor_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pulse meter: period and low time of one pin
// ****************************************
module cstg_pulse_meter (
  input  wire logic        clk_i,    // sys clock
  input  wire logic        sig_i,    // watched pin
  output logic      [15:0] period_o, // cycles between falling edges
  output logic      [15:0] low_o     // cycles low in the last pulse
);
  logic        last;  // previous sample
  logic [15:0] since; // cycles since the last fall
  // restart at every fall, latch the period there and the low time at the rise
  always_ff @(posedge clk_i) begin
    last <= sig_i;
    since <= (last && !sig_i) ? 16'h0001 : since + 16'h0001;
    if (last && !sig_i) period_o <= since;
    if (!last && sig_i) low_o <= since;
  end
endmodule // cstg_pulse_meter

// ****************************************
// monitor and timing clock source
// ****************************************
module cstg_monitor_model (
  input  wire logic        clk_i,         // sys clock
  input  wire logic        hsync_i,       // horizontal sync pin
  input  wire logic        vsync_i,       // vertical sync pin
  input  wire logic        blank_n_i,     // composite blank pin
  input  wire logic [7:0]  ext_len_i,     // external line length in ticks, 0 = off
  output logic             char_clk_o,    // timing clock, sys clock / 4
  output logic             ext_hsync_n_o, // external horizontal sync
  output logic             ext_vsync_n_o, // external vertical sync, idle
  output logic      [15:0] h_period_o,    // hsync period in cycles
  output logic      [15:0] h_low_o,       // hsync low cycles
  output logic      [15:0] v_period_o,    // vsync period in cycles
  output logic      [15:0] v_low_o,       // vsync low cycles
  output logic      [15:0] frame_disp_o,  // blank_n high cycles per frame
  output logic             h_edge_o,      // timing clock level just after hsync fell
  output logic      [15:0] lead_o         // cycles from hsync fall to blank_n rise
);
  logic [1:0]  phase = 2'h0; // timing clock divider
  logic [7:0]  ecnt  = 8'h00; // ticks into the external line
  logic [15:0] disp  = 16'h0000; // running display count
  logic        vlast = 1'b1; // previous vsync sample
  logic        hlast = 1'b1; // previous hsync sample
  logic        blast = 1'b0; // previous blank sample
  logic [15:0] lead  = 16'h0000; // cycles since hsync fell
  assign char_clk_o = phase[1]; // each count covers several pixels
  assign ext_vsync_n_o = 1'b1;
  // external sync changes only on the tick edge, so it lines up with a tick
  always_ff @(posedge clk_i) begin
    phase <= phase + 2'h1;
    if (phase == 2'h1) ecnt <= (ecnt + 8'h01 >= ext_len_i) ? 8'h00 : ecnt + 8'h01;
    if (phase == 2'h1) ext_hsync_n_o <= !((ext_len_i != 8'h00) && (ecnt == 8'h00));
    vlast <= vsync_i;
    disp <= (vlast && !vsync_i) ? {15'h0000, blank_n_i} : disp + {15'h0000, blank_n_i};
    if (vlast && !vsync_i) frame_disp_o <= disp;
    hlast <= hsync_i;
    blast <= blank_n_i;
    lead <= (hlast && !hsync_i) ? 16'h0001 : lead + 16'h0001;
    // the clock level right after the fall shows which edge moved the pin
    if (hlast && !hsync_i) h_edge_o <= char_clk_o;
    if (!blast && blank_n_i) lead_o <= lead;
  end
  cstg_pulse_meter hm_inst (.clk_i(clk_i), .sig_i(hsync_i), .period_o(h_period_o),
    .low_o(h_low_o));
  cstg_pulse_meter vm_inst (.clk_i(clk_i), .sig_i(vsync_i), .period_o(v_period_o),
    .low_o(v_low_o));
endmodule // cstg_monitor_model
`default_nettype wire

// [test/cstg_timing_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cstg_params.svh"
module cstg_timing_tb;
  import cstg_pkg::*;
  logic        sys_clk_i = 1'b0, rst_i = 1'b1;      // clock and reset
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;   // bus request
  logic [7:0]  adr = 8'h00, ext_len = 8'h00;        // address, ext line length
  logic [31:0] wdat = 32'h0, rdat, dat_o;           // data
  logic        ack, hs, vs, bn, ctc, ehs, evs;      // pins
  logic [15:0] hp, hl, vp, vl, fd, ld;              // partner measurements
  logic        he;                                  // timing clock level at hsync fall
  int          n_mismatch = 0, samples_checked = 0, cycles = 0;
  logic [11:0] rst_val [9] = '{12'h000, `CSTG_HRZT_RST, `CSTG_HRZSR_RST, `CSTG_HRZBR_RST,
    `CSTG_HRZBF_RST, `CSTG_VRTT_RST, `CSTG_VRTSR_RST, `CSTG_VRTBR_RST, `CSTG_VRTBF_RST};
  // small frame: 16 ticks a line, 6 lines a frame
  logic [11:0] lim [8] = '{12'h00f, 12'h001, 12'h003, 12'h00b, 12'h006, 12'h001, 12'h002,
    12'h004};
  cstg_timing cstg_timing_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .char_timing_clock_i(ctc),
    .ext_hsync_n_i(ehs), .ext_vsync_n_i(evs), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .hsync_o(hs), .vsync_o(vs), .blank_n_o(bn));
  cstg_monitor_model cstg_monitor_model_inst (.clk_i(sys_clk_i), .hsync_i(hs), .vsync_i(vs),
    .blank_n_i(bn), .ext_len_i(ext_len), .char_clk_o(ctc), .ext_hsync_n_o(ehs),
    .ext_vsync_n_o(evs), .h_period_o(hp), .h_low_o(hl), .v_period_o(vp), .v_low_o(vl),
    .frame_disp_o(fd), .h_edge_o(he), .lead_o(ld));
  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    forever #20 sys_clk_i = !sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle, held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge sys_clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("hsync at reset", 32'h1, {31'h0, hs});
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", {20'h0, rst_val[i]}, rdat);
    end
    wb(1'b1, 8'h40, 32'hffff);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rdat);
    $display("test reset done");
  endtask
  // limits as count-1 horizontally, full count vertically, ascending
  task automatic t_frame();
    for (int i = 0; i < 8; i++) wb(1'b1, 8'(`CSTG_OFF_LIM0 + 4 * i), {20'h0, lim[i]});
    wb(1'b0, `CSTG_OFF_LIM0, 32'h0);
    chk("limit readback", 32'h00f, rdat);
    wait_cycles(1200);
    chk("line period", 32'd64, {16'h0, hp});
    chk("hsync low", 32'd8, {16'h0, hl});
    chk("frame period", 32'd384, {16'h0, vp});
    chk("vsync low", 32'd64, {16'h0, vl});
    chk("display per frame", 32'd64, {16'h0, fd});
    chk("blank lead", 32'((lim[2] + 12'h1) * 4), {16'h0, ld});
    chk("sync edge level", 32'h1, {31'h0, he});
    $display("test frame done");
  endtask
  task automatic t_polarity();
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, `CSTG_OFF_CTRL, 32'(p << 4));
      wait_cycles(200);
      if (p < 2) chk("hsync low width", (p == 0) ? 32'd8 : 32'd56, {16'h0, hl});
      for (int c = 0; c < 70 && p >= 2; c++) begin
        @(posedge sys_clk_i);
        chk("forced hsync", 32'(p - 2), {31'h0, hs});
      end
    end
    wb(1'b1, `CSTG_OFF_CTRL, 32'h80);
    // pins only move on a timing tick, so allow two tick periods
    wait_cycles(8);
    chk("forced vsync", 32'h0, {31'h0, vs});
    wb(1'b1, `CSTG_OFF_CTRL, 32'h0);
    $display("test polarity done");
  endtask
  task automatic t_ext();
    ext_len <= 8'd10;
    wb(1'b1, `CSTG_OFF_CTRL, 32'h1);
    wait_cycles(400);
    chk("external line period", 32'd40, {16'h0, hp});
    $display("test external sync done");
  endtask
  // falling-edge pins and a blank delay of two ticks, four sys cycles each
  task automatic t_delay();
    wb(1'b1, `CSTG_OFF_CTRL, 32'h0a);
    wait_cycles(800);
    chk("sync edge level", 32'h0, {31'h0, he});
    chk("delayed blank lead", 32'((lim[2] + 12'h3) * 4), {16'h0, ld});
    chk("delayed display per frame", 32'd64, {16'h0, fd});
    chk("line period falling edge", 32'd64, {16'h0, hp});
    wb(1'b1, `CSTG_OFF_CTRL, 32'h0);
    $display("test blank delay done");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    wait_cycles(16);
    rst_i <= 1'b0;
    wait_cycles(2);
    t_reset();
    t_frame();
    t_polarity();
    t_delay();
    t_ext();
    end_of_test();
  end
endmodule // cstg_timing_tb
`default_nettype wire
